// File: core/mcr_modem_cfg.v
/*
 * Modem configuration register bank of the baseband modulator: symbol rate
 * mantissa and exponent, modulation format, Manchester enable, sync-word
 * length and minimum preamble length, plus the decoded controls that the
 * modulator and packet engine use.
 * Assumes a synchronous register port driven by the device's serial
 * interface logic, and a packet-format field supplied by the packet
 * control registers elsewhere in the device.
 */
// Notes on behaviour
// RULE_01 - Rate exponent sits in bits 3:0 of first register, resets to twelve, read/write.
// RULE_02 - Stored eight-bit mantissa gains a hidden ninth bit of one.
// RULE_03 - Symbol rate equals clock times (256 + mantissa) times 2^exponent over 2^28.
// RULE_04 - Bits 6:4 select 2-FSK, GFSK, OOK or 4-FSK; others reserved; reset 2-FSK.
// RULE_05 - Bit 3 enables Manchester; software clears it for 4-FSK or asynchronous mode.
// RULE_06 - Bits 2:0 select no sync, 16-bit or 32-bit sync; reset is reserved 010.
// RULE_07 - Preamble field 6:4 gives 2,3,4,6,8,12,16,24 bytes; resets to four bytes.
// RULE_08 - Packet format three takes transmit data from general pin zero, not FIFO.
// RULE_09 - Software avoids reserved selector codes; their effect is left undefined.
`timescale 1ns/1ps
`include "mcr_defs.vh"

module mcr_modem_cfg #(
	parameter ACC_W = `MCR_ACC_W
) (
	input wire clk,
	input wire rst,
	input wire [`MCR_ADDR_W-1:0] reg_addr,
	input wire reg_wr,
	input wire [7:0] reg_wdata,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	output reg reg_hit,
	input wire [1:0] tx_data_source,
	input wire gp_pin_zero,
	input wire fifo_tx_bit,
	output reg [3:0] rate_exponent,
	output reg [7:0] rate_mantissa,
	output reg [2:0] modulation_select,
	output reg mod_reserved,
	output reg manchester_active,
	output reg sync_enable,
	output reg [5:0] sync_word_bits,
	output reg sync_reserved,
	output reg [4:0] preamble_bytes,
	output reg tx_async_mode,
	output reg tx_bit,
	output wire symbol_tick
);
	reg [7:0] rate_exp_cfg;
	reg [7:0] rate_mant_cfg;
	reg [7:0] mod_sync_cfg;
	reg [7:0] preamble_cfg;
	reg [7:0] next_rdata;
	reg next_hit;
	wire [2:0] mod_field;
	wire [2:0] sync_field;
	wire async_sel;

	function [4:0] preamble_count;
		input [2:0] code;
		begin
			case (code)
				3'h0: preamble_count = 5'h02;
				3'h1: preamble_count = 5'h03;
				3'h2: preamble_count = 5'h04;
				3'h3: preamble_count = 5'h06;
				3'h4: preamble_count = 5'h08;
				3'h5: preamble_count = 5'h0c;
				3'h6: preamble_count = 5'h10;
				default: preamble_count = 5'h18;
			endcase
		end
	endfunction

	function [5:0] sync_length;
		input [2:0] code;
		begin
			case (code)
				`MCR_SYNC_16: sync_length = 6'h10;
				`MCR_SYNC_32: sync_length = 6'h20;
				default: sync_length = 6'h00;
			endcase
		end
	endfunction

	function mod_is_reserved;
		input [2:0] code;
		begin
			case (code)
				`MCR_MOD_2FSK, `MCR_MOD_GFSK, `MCR_MOD_OOK, `MCR_MOD_4FSK: mod_is_reserved = 1'b0;
				default: mod_is_reserved = 1'b1;
			endcase
		end
	endfunction

	function sync_is_reserved;
		input [2:0] code;
		begin
			case (code)
				`MCR_SYNC_NONE, `MCR_SYNC_16, `MCR_SYNC_32: sync_is_reserved = 1'b0;
				default: sync_is_reserved = 1'b1;
			endcase
		end
	endfunction

	// Manchester coding cannot pair with four-level FSK or with the asynchronous pin path.
	function manchester_allowed;
		input [2:0] mod_code;
		input async_path;
		begin
			manchester_allowed = (mod_code != `MCR_MOD_4FSK) && !async_path;
		end
	endfunction

	assign mod_field = mod_sync_cfg[`MCR_MOD_MSB:`MCR_MOD_LSB];
	assign sync_field = mod_sync_cfg[`MCR_SYNC_MSB:`MCR_SYNC_LSB];
	assign async_sel = (tx_data_source == `MCR_SRC_ASYNC);

	// Register writes; the unused bits 3:2 of the preamble register are masked so they read zero.
	always @(posedge clk) begin
		if (rst) begin
			rate_exp_cfg <= `MCR_RST_RATE_EXP; // RULE_01
			rate_mant_cfg <= `MCR_RST_RATE_MANT;
			mod_sync_cfg <= `MCR_RST_MOD_SYNC; // RULE_04 RULE_05 RULE_06
			preamble_cfg <= `MCR_RST_PREAMBLE; // RULE_07
		end else if (reg_wr) begin
			case (reg_addr)
				`MCR_OFS_RATE_EXP: rate_exp_cfg <= reg_wdata & `MCR_MASK_RATE_EXP; // RULE_01
				`MCR_OFS_RATE_MANT: rate_mant_cfg <= reg_wdata & `MCR_MASK_RATE_MANT;
				`MCR_OFS_MOD_SYNC: mod_sync_cfg <= reg_wdata & `MCR_MASK_MOD_SYNC;
				`MCR_OFS_PREAMBLE: preamble_cfg <= reg_wdata & `MCR_MASK_PREAMBLE;
				default: rate_exp_cfg <= rate_exp_cfg;
			endcase
		end
	end

	// Reads have no side effects; an unmapped address answers zero with reg_hit low.
	always @* begin
		next_rdata = 8'h00;
		next_hit = 1'b1;
		case (reg_addr)
			`MCR_OFS_RATE_EXP: next_rdata = rate_exp_cfg;
			`MCR_OFS_RATE_MANT: next_rdata = rate_mant_cfg;
			`MCR_OFS_MOD_SYNC: next_rdata = mod_sync_cfg;
			`MCR_OFS_PREAMBLE: next_rdata = preamble_cfg;
			default: next_hit = 1'b0;
		endcase
	end

	always @(posedge clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
			reg_hit <= 1'b0;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
			reg_hit <= next_hit;
		end
	end

	// Decoded controls are registered so every output comes from a flip-flop;
	// the cost is one clock of latency after a register write.
	always @(posedge clk) begin
		if (rst) begin
			rate_exponent <= 4'h0;
			rate_mantissa <= 8'h00;
		end else begin
			rate_exponent <= rate_exp_cfg[`MCR_EXP_MSB:`MCR_EXP_LSB]; // RULE_01
			rate_mantissa <= rate_mant_cfg; // RULE_02
		end
	end

	// Modulation format and the Manchester enable that depends on it.
	always @(posedge clk) begin
		if (rst) begin
			modulation_select <= 3'h0;
			mod_reserved <= 1'b0;
			manchester_active <= 1'b0;
		end else begin
			modulation_select <= mod_field; // RULE_04
			// Reserved codes are flagged, not corrected; their effect stays undefined.
			mod_reserved <= mod_is_reserved(mod_field); // RULE_09
			// Manchester is held off as a guard if software breaks its side of the deal.
			manchester_active <= mod_sync_cfg[`MCR_MANCH_BIT] &&
				manchester_allowed(mod_field, async_sel); // RULE_05
		end
	end

	// Sync word and preamble length for the packet engine.
	always @(posedge clk) begin
		if (rst) begin
			sync_enable <= 1'b0;
			sync_word_bits <= 6'h00;
			sync_reserved <= 1'b0;
			preamble_bytes <= 5'h00;
		end else begin
			sync_enable <= (sync_field != `MCR_SYNC_NONE); // RULE_06
			sync_word_bits <= sync_length(sync_field); // RULE_06
			// The reset code is reserved, so this flag stays up until software reprograms it.
			sync_reserved <= sync_is_reserved(sync_field); // RULE_09
			preamble_bytes <= preamble_count(preamble_cfg[`MCR_PRE_MSB:`MCR_PRE_LSB]); // RULE_07
		end
	end

	// Transmit data path; the selected source is resampled every clock,
	// which adds one clock of delay between the pin and the modulator.
	always @(posedge clk) begin
		if (rst) begin
			tx_async_mode <= 1'b0;
			tx_bit <= 1'b0;
		end else begin
			tx_async_mode <= async_sel; // RULE_08
			tx_bit <= async_sel ? gp_pin_zero : fifo_tx_bit; // RULE_08
		end
	end

	// The generator reads the stored fields directly, so a rate write reaches the
	// accumulator one clock before the decoded rate copies show it.
	mcr_rate_gen #(
		.ACC_W(ACC_W)
	) u_rate (
		.clk(clk),
		.rst(rst),
		.rate_mantissa(rate_mant_cfg),
		.rate_exponent(rate_exp_cfg[`MCR_EXP_MSB:`MCR_EXP_LSB]),
		.symbol_tick(symbol_tick)
	);
endmodule

// File: core/mcr_defs.vh
/*
 * Constants of the modem configuration register bank: register offsets,
 * field positions, reset values, write masks and format codes.
 * Assumes it is included by bare name from files under core/.
 */
`ifndef MCR_DEFS_VH
`define MCR_DEFS_VH

`define MCR_ADDR_W 6
`define MCR_OFS_RATE_EXP 6'h10
`define MCR_OFS_RATE_MANT 6'h11
`define MCR_OFS_MOD_SYNC 6'h12
`define MCR_OFS_PREAMBLE 6'h13

`define MCR_RST_RATE_EXP 8'h8c
`define MCR_RST_RATE_MANT 8'h22
`define MCR_RST_MOD_SYNC 8'h02
`define MCR_RST_PREAMBLE 8'h22

`define MCR_MASK_RATE_EXP 8'hff
`define MCR_MASK_RATE_MANT 8'hff
`define MCR_MASK_MOD_SYNC 8'hff
`define MCR_MASK_PREAMBLE 8'hf3

`define MCR_EXP_MSB 3
`define MCR_EXP_LSB 0
`define MCR_MOD_MSB 6
`define MCR_MOD_LSB 4
`define MCR_MANCH_BIT 3
`define MCR_SYNC_MSB 2
`define MCR_SYNC_LSB 0
`define MCR_PRE_MSB 6
`define MCR_PRE_LSB 4

`define MCR_MOD_2FSK 3'h0
`define MCR_MOD_GFSK 3'h1
`define MCR_MOD_OOK 3'h3
`define MCR_MOD_4FSK 3'h4

`define MCR_SYNC_NONE 3'h0
`define MCR_SYNC_16 3'h1
`define MCR_SYNC_32 3'h3

`define MCR_SRC_ASYNC 2'h3

`define MCR_MANT_HIDDEN 9'h100
`define MCR_ACC_W 28

`endif

// File: core/mcr_rate_gen.v
/*
 * Symbol-rate strobe generator: a phase accumulator that advances by the
 * floating-point rate word each clock and pulses on every wrap of 2^28.
 * Assumes clk is the crystal-derived clock and the rate fields are stable
 * registers from the configuration bank.
 */
`timescale 1ns/1ps
`include "mcr_defs.vh"

module mcr_rate_gen #(
	parameter ACC_W = `MCR_ACC_W
) (
	input wire clk,
	input wire rst,
	input wire [7:0] rate_mantissa,
	input wire [3:0] rate_exponent,
	output reg symbol_tick
);
	reg [ACC_W-1:0] phase;
	wire [ACC_W:0] step;
	wire [ACC_W:0] sum;

	// The hidden ninth mantissa bit is added here so software only stores eight bits.
	assign step = {{(ACC_W-8){1'b0}}, `MCR_MANT_HIDDEN | {1'b0, rate_mantissa}} << rate_exponent; // RULE_02
	assign sum = {1'b0, phase} + step;

	always @(posedge clk) begin
		if (rst) begin
			phase <= {ACC_W{1'b0}};
			symbol_tick <= 1'b0;
		end else begin
			phase <= sum[ACC_W-1:0];
			symbol_tick <= sum[ACC_W]; // RULE_03
		end
	end
endmodule

// File: sim/mcr_modem_cfg_assertions.sv
/* Port-level checks of the modem configuration bank.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module mcr_chk (
	input logic clk,
	input logic rst,
	input logic [5:0] reg_addr,
	input logic reg_wr,
	input logic [7:0] reg_wdata,
	input logic reg_rd,
	input logic [7:0] reg_rdata,
	input logic reg_hit,
	input logic [1:0] tx_data_source,
	input logic gp_pin_zero,
	input logic fifo_tx_bit,
	input logic [3:0] rate_exponent,
	input logic [7:0] rate_mantissa,
	input logic [2:0] modulation_select,
	input logic manchester_active,
	input logic [4:0] preamble_bytes,
	input logic tx_bit,
	input logic symbol_tick
);
	logic [7:0] wd1;
	logic [7:0] wd2;
	// Write data two edges back lines up with the decoded outputs.
	always @(posedge clk) begin
		wd1 <= reg_wdata;
		wd2 <= wd1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_wr(logic [5:0] a);
		reg_wr && reg_addr == a;
	endsequence
	a_exp_follow: assert property (
		s_wr(6'h10) |=> ##1 rate_exponent == wd2[3:0]) else $error("exponent lost");
	a_mant_follow: assert property (
		s_wr(6'h11) |=> ##1 rate_mantissa == wd2) else $error("mantissa lost");
	a_pre_decode: assert property (
		s_wr(6'h13) |=> ##1 preamble_bytes == (wd2[4] ? 5'd3 : 5'd2) << wd2[6:5])
		else $error("preamble decode wrong");
	a_read_mapped: assert property (
		reg_rd && reg_addr inside {[6'h10:6'h13]} |=> reg_hit) else $error("mapped read missed");
	a_read_unmapped: assert property (
		reg_rd && !(reg_addr inside {[6'h10:6'h13]}) |=> !reg_hit && reg_rdata == 8'h00)
		else $error("unmapped read not empty");
	a_manch_guard: assert property (
		manchester_active |-> modulation_select != 3'h4 && $past(tx_data_source) != 2'h3)
		else $error("coding on in forbidden mode");
	a_data_mux: assert property (
		!$past(rst) |-> tx_bit == $past(tx_data_source == 2'h3 ? gp_pin_zero : fifo_tx_bit))
		else $error("data source wrong");
	a_tick_single: assert property (
		symbol_tick |=> !symbol_tick) else $error("tick too long");
endmodule
bind mcr_modem_cfg mcr_chk u_mcr_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.reg_hit(reg_hit), .tx_data_source(tx_data_source), .gp_pin_zero(gp_pin_zero),
	.fifo_tx_bit(fifo_tx_bit), .rate_exponent(rate_exponent), .rate_mantissa(rate_mantissa),
	.modulation_select(modulation_select), .manchester_active(manchester_active),
	.preamble_bytes(preamble_bytes), .tx_bit(tx_bit), .symbol_tick(symbol_tick));

// File: sim/testbench.sv
/* Self-checking bench for the modem configuration bank.
   Assumes the bank runs alone, with its register port driven here. */
`timescale 1ns/1ps
module testbench;
	logic clk, rst, reg_wr, reg_rd, gp, fb;
	logic [5:0] ra, a;
	logic [7:0] wd, d, v;
	logic [7:0] mdl [4];
	logic [1:0] src;
	wire [7:0] rdat, rm;
	wire [3:0] re;
	wire [2:0] ms;
	wire [5:0] swb;
	wire [4:0] pb;
	wire hit, mr, mch, se, sr, am, tb, tk;
	int num_errors = 0, compares = 0, n, c;
	mcr_modem_cfg u_mcr_modem_cfg (.clk(clk), .rst(rst), .reg_addr(ra), .reg_wr(reg_wr),
		.reg_wdata(wd), .reg_rd(reg_rd), .reg_rdata(rdat), .reg_hit(hit), .tx_data_source(src),
		.gp_pin_zero(gp), .fifo_tx_bit(fb), .rate_exponent(re), .rate_mantissa(rm),
		.modulation_select(ms), .mod_reserved(mr), .manchester_active(mch), .sync_enable(se),
		.sync_word_bits(swb), .sync_reserved(sr), .preamble_bytes(pb), .tx_async_mode(am),
		.tx_bit(tb), .symbol_tick(tk));
	task chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Minimum preamble bytes for each code of the preamble field.
	function automatic logic [7:0] pre_bytes(input logic [2:0] code);
		case (code)
			3'h0: return 8'h02;
			3'h1: return 8'h03;
			3'h2: return 8'h04;
			3'h3: return 8'h06;
			3'h4: return 8'h08;
			3'h5: return 8'h0c;
			3'h6: return 8'h10;
			default: return 8'h18;
		endcase
	endfunction
	// Software side of the format rules: no reserved codes and Manchester left off.
	function automatic logic [7:0] legal_mod_sync(input logic [7:0] raw);
		logic [7:0] r;
		r = raw & 8'hf7;
		if (r[6:4] == 3'h2 || r[6:4] > 3'h4)
			r[6:4] = 3'h1;
		if (r[2:0] == 3'h2 || r[2:0] > 3'h3)
			r[2:0] = 3'h3;
		return r;
	endfunction
	task wr(input logic [5:0] ad, input logic [7:0] val);
		@(posedge clk);
		ra <= ad;
		wd <= val;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [5:0] ad);
		@(posedge clk);
		ra <= ad;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = rdat;
	endtask
	// Counts cycles up to the next tick; bounded so a dead generator cannot hang.
	task tick;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (tk !== 1'b1 && n < 300);
	endtask
	task close_out;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		close_out;
	end
	initial begin
		{rst, reg_wr, reg_rd, gp, fb, src, ra, wd} <= {5'h10, 2'h0, 6'h00, 8'h00};
		mdl = '{8'h8c, 8'h22, 8'h02, 8'h22};
		void'($urandom(32'h5d0a6049));
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		for (c = 0; c < 4; c++) begin
			rd(6'h10 + 6'(c));
			chk(d, mdl[c]);
		end
		chk({re, ms, sr}, 8'hc1);
		chk(pb, 8'h04);
		wr(6'h10, 8'h0e);
		wr(6'h11, 8'h00);
		repeat (3) tick;
		chk(8'(n), 8'd64);
		wr(6'h10, 8'h0f);
		repeat (3) tick;
		chk(8'(n), 8'd32);
		mdl[0] = 8'h0f;
		mdl[1] = 8'h00;
		for (c = 0; c < 8; c++) begin
			@(posedge clk);
			src <= 2'(c);
			v = {1'b0, 3'(c), 1'b1, 3'(c)};
			wr(6'h12, v);
			wr(6'h13, v);
			@(posedge clk);
			#1;
			chk({ms, mr}, {3'(c), c == 2 || c > 4});
			chk(mch, c != 4 && c != 3 && c != 7);
			chk({se, sr}, {c != 0, c != 0 && c != 1 && c != 3});
			chk(swb, c == 1 ? 16 : c == 3 ? 32 : 0);
			chk(pb, pre_bytes(3'(c)));
		end
		mdl[2] = 8'h7f;
		mdl[3] = 8'h73;
		for (c = 0; c < 40; c++) begin
			@(posedge clk);
			{src, gp, fb} <= 4'($urandom);
			a = 6'h10 + 6'($urandom_range(4));
			v = 8'($urandom);
			if (a == 6'h12) v = legal_mod_sync(v);
			wr(a, v);
			if (a < 6'h14) mdl[a[1:0]] = (a == 6'h13) ? v & 8'hf3 : v;
			rd(a);
			chk(d, a < 6'h14 ? mdl[a[1:0]] : 8'h00);
			chk({hit, re}, {a < 6'h14, mdl[0][3:0]});
			chk(rm, mdl[1]);
			chk({am, tb}, {src == 2'h3, src == 2'h3 ? gp : fb});
		end
		close_out;
	end
endmodule
